// ==== cpu_core_model.sv ====
// CPU core stand-in giving the sampling strobe and machine-cycle pulses.
// Assumes one machine cycle per clock and no early acknowledge.
`timescale 1ns/1ps
module cpu_core_model #(parameter int GAP = 3) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic busy_i,
  input wire logic req_i,
  output logic sample_o,
  output logic machine_cycle_o
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || busy_i || cnt_r == GAP[3:0]) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  assign sample_o = !rst_i && !busy_i && req_i && cnt_r == GAP[3:0];
  assign machine_cycle_o = !rst_i;
endmodule

// ==== intc_pkg.sv ====
// Types shared by the interrupt controller.
// Assumes the constants header is included alongside.
package intc_pkg;
  typedef struct packed {
    logic        req;
    logic [3:0]  src;
    logic [15:0] vector;
  } cpu_request_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_access_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCEPT
  } accept_state_t;
endpackage

// ==== intc_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the interrupt controller.
// Assumes an 8-bit special-function register port with byte addresses.
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH

`define ENABLE_WORD_LO_ADDR 8'h3A
`define ENABLE_WORD_HI_ADDR 8'h3B
`define REQUEST_LATCH_LO_ADDR 8'h3C
`define REQUEST_LATCH_HI_ADDR 8'h3D
`define MASTER_ENABLE_BIT 0
`define ENABLE_WORD_RESET 16'h0000
`define REQUEST_LATCH_RESET 16'h0000
`define SOURCE_SOFTWARE 4'h1
`define SOURCE_WATCHDOG 4'h2
`define SOURCE_PIN0 4'h3
`define VECTOR_TOP 16'hFFFE
`define ACCEPT_MACHINE_CYCLES 4'h8

`endif

// ==== prioritized_interrupt_controller.sv ====
// Prioritized interrupt controller with request latches, enable word and vector output.
// Assumes the CPU core drives the sampling, acknowledge, return and enable strobes.
//
// Contract
// - Fifteen sources, six external, nine internal.
// - Software and watchdog are pseudo non-maskable.
// - Highest fixed priority wins, reset through pin 5.
// - Vectors descend by two from top word.
// - Each non-software source has a set latch.
// - Acceptance clears the accepted source latch.
// - Reset forces all latches to zero.
// - Latch writes clear only, never set.
// - Latches are readable by software.
// - Enable word is fully readable and writable; the code holds bits 3..1 at zero.
// - Master flag is bit zero, instructions control it.
// - Maskable needs master and own enable flag.
// - Pin 0 gated by master and function enable.
// - Any acceptance clears the master flag.
// - Maskable return sets master flag again.
// - Nonmaskable return restores master flag conditionally.
// - No pseudo non-maskable nesting; watchdog waits.
// - Enabled request with master ends sleep mode; the code wakes on an enabled request even with the master flag clear.
// - Watchdog just before sleep cancels sleep entry.
// - Acceptance takes eight machine cycles.
// - Requests sampled in instruction final cycle.
`timescale 1ns/1ps
`include "intc_regs.svh"

module prioritized_interrupt_controller (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [15:2] source_pulse_i,
  input wire logic software_trap_i,
  input wire logic pin0_function_enable_i,
  input wire intc_pkg::sfr_access_t sfr_i,
  input wire logic sample_i,
  input wire logic machine_cycle_i,
  input wire logic accept_ack_i,
  input wire logic maskable_return_i,
  input wire logic nonmaskable_return_i,
  input wire logic enable_instruction_i,
  input wire logic disable_instruction_i,
  input wire logic sleep_request_i,
  output intc_pkg::cpu_request_t cpu_req_o,
  output logic [7:0] sfr_rdata_o,
  output logic accept_busy_o,
  output logic sleep_fast_clock_o
);

  logic [15:0] request_latch_r;
  logic [15:0] enable_word_r;
  logic nmi_active_r;
  logic nmi_saved_master_r;
  logic [3:0] accept_src_r;
  logic [3:0] accept_cnt_r;
  intc_pkg::accept_state_t state_r;
  logic [15:0] pending;
  logic [15:0] eligible;
  logic [3:0] winner;
  logic any_eligible;
  logic wake;
  logic accept_start;
  logic accept_done;
  logic lo_clear;
  logic hi_clear;

  // Eligibility per source; bit 1 is the software trap, bits 15..2 are latches.
  always_comb begin
    pending = {request_latch_r[15:2], software_trap_i, 1'b0};
    eligible = 16'h0000;
    eligible[1] = pending[1] & ~nmi_active_r;
    eligible[2] = pending[2] & ~nmi_active_r;
    eligible[3] = pending[3] & enable_word_r[`MASTER_ENABLE_BIT] & pin0_function_enable_i;
    for (int i = 4; i < 16; i++) begin
      eligible[i] = pending[i] & enable_word_r[`MASTER_ENABLE_BIT] & enable_word_r[i];
    end
  end

  // Fixed priority: lowest index wins.
  always_comb begin
    winner = 4'h0;
    any_eligible = 1'b0;
    for (int i = 15; i >= 1; i--) begin
      if (eligible[i]) begin
        winner = 4'(i);
        any_eligible = 1'b1;
      end
    end
  end

  assign accept_start = (state_r == intc_pkg::ST_IDLE) && sample_i && any_eligible;
  assign accept_done = (state_r == intc_pkg::ST_ACCEPT) && accept_ack_i;
  assign wake = |(pending[15:4] & enable_word_r[15:4]) || (pending[3] && pin0_function_enable_i)
    || pending[2];
  assign lo_clear = sfr_i.wr && (sfr_i.addr == `REQUEST_LATCH_LO_ADDR);
  assign hi_clear = sfr_i.wr && (sfr_i.addr == `REQUEST_LATCH_HI_ADDR);

  // Acceptance sequence lasting eight machine cycles.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_r <= intc_pkg::ST_IDLE;
      accept_src_r <= 4'h0;
      accept_cnt_r <= 4'h0;
    end else begin
      case (state_r)
        intc_pkg::ST_IDLE: begin
          if (accept_start) begin
            state_r <= intc_pkg::ST_ACCEPT;
            accept_src_r <= winner;
            accept_cnt_r <= `ACCEPT_MACHINE_CYCLES;
          end
        end
        intc_pkg::ST_ACCEPT: begin
          if (machine_cycle_i && accept_cnt_r != 4'h0) begin
            accept_cnt_r <= accept_cnt_r - 4'h1;
          end
          if (accept_done || (machine_cycle_i && accept_cnt_r == 4'h1)) begin
            state_r <= intc_pkg::ST_IDLE;
          end
        end
        default: state_r <= intc_pkg::ST_IDLE;
      endcase
    end
  end

  // Request latches: hardware set wins over software clear.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      request_latch_r <= `REQUEST_LATCH_RESET;
    end else begin
      for (int i = 2; i < 16; i++) begin
        if (source_pulse_i[i]) begin
          request_latch_r[i] <= 1'b1;
        end else if (accept_start && winner == 4'(i)) begin
          request_latch_r[i] <= 1'b0;
        end else if (lo_clear && i < 8 && !sfr_i.wdata[i % 8]) begin
          request_latch_r[i] <= 1'b0;
        end else if (hi_clear && i >= 8 && !sfr_i.wdata[i % 8]) begin
          request_latch_r[i] <= 1'b0;
        end
      end
      request_latch_r[1:0] <= 2'b00;
    end
  end

  // Enable word with master flag handling.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      enable_word_r <= `ENABLE_WORD_RESET;
    end else begin
      if (sfr_i.wr && sfr_i.addr == `ENABLE_WORD_LO_ADDR) begin
        enable_word_r[7:0] <= sfr_i.wdata;
      end
      if (sfr_i.wr && sfr_i.addr == `ENABLE_WORD_HI_ADDR) begin
        enable_word_r[15:8] <= sfr_i.wdata;
      end
      if (enable_instruction_i) begin
        enable_word_r[`MASTER_ENABLE_BIT] <= 1'b1;
      end
      if (disable_instruction_i) begin
        enable_word_r[`MASTER_ENABLE_BIT] <= 1'b0;
      end
      if (maskable_return_i) begin
        enable_word_r[`MASTER_ENABLE_BIT] <= 1'b1;
      end
      if (nonmaskable_return_i && nmi_active_r) begin
        enable_word_r[`MASTER_ENABLE_BIT] <= nmi_saved_master_r;
      end
      if (accept_start) begin
        enable_word_r[`MASTER_ENABLE_BIT] <= 1'b0;
      end
      enable_word_r[3:1] <= 3'b000;
    end
  end

  // Pseudo non-maskable service tracking.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      nmi_active_r <= 1'b0;
      nmi_saved_master_r <= 1'b0;
    end else if (accept_start && (winner == `SOURCE_SOFTWARE || winner == `SOURCE_WATCHDOG)) begin
      nmi_active_r <= 1'b1;
      nmi_saved_master_r <= enable_word_r[`MASTER_ENABLE_BIT];
    end else if (nonmaskable_return_i) begin
      nmi_active_r <= 1'b0;
    end
  end

  // CPU facing request, vector and read data.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cpu_req_o <= '0;
      sfr_rdata_o <= 8'h00;
      accept_busy_o <= 1'b0;
      sleep_fast_clock_o <= 1'b0;
    end else begin
      cpu_req_o.req <= any_eligible && state_r == intc_pkg::ST_IDLE && !accept_start;
      cpu_req_o.src <= winner;
      cpu_req_o.vector <= `VECTOR_TOP - {11'h000, winner, 1'b0};
      accept_busy_o <= accept_start || (state_r == intc_pkg::ST_ACCEPT && !accept_done);
      if (wake || accept_start) begin
        sleep_fast_clock_o <= 1'b0;
      end else if (sleep_request_i) begin
        sleep_fast_clock_o <= 1'b1;
      end
      case (sfr_i.addr)
        `ENABLE_WORD_LO_ADDR: sfr_rdata_o <= enable_word_r[7:0];
        `ENABLE_WORD_HI_ADDR: sfr_rdata_o <= enable_word_r[15:8];
        `REQUEST_LATCH_LO_ADDR: sfr_rdata_o <= request_latch_r[7:0];
        `REQUEST_LATCH_HI_ADDR: sfr_rdata_o <= request_latch_r[15:8];
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

// ==== prioritized_interrupt_controller_properties.sv ====
// Concurrent checks on the interrupt controller ports.
// Assumes it is bound to the controller top and sees one machine cycle per clock.
`timescale 1ns/1ps
module intc_checker (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic software_trap_i,
  input wire intc_pkg::sfr_access_t sfr_i,
  input wire logic sample_i,
  input wire intc_pkg::cpu_request_t cpu_req_o,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic accept_busy_o,
  input wire logic sleep_fast_clock_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  vector_step_a: assert property (cpu_req_o.req |->
    cpu_req_o.vector == 16'hFFFE - {11'h000, cpu_req_o.src, 1'b0}) else $error("bad vector");
  source_range_a: assert property (cpu_req_o.req |-> cpu_req_o.src != 4'h0)
    else $error("bad source");
  trap_cause_a: assert property (cpu_req_o.req && cpu_req_o.src == 4'h1 |->
    $past(software_trap_i)) else $error("trap without cause");
  quiet_busy_a: assert property (accept_busy_o |-> !cpu_req_o.req)
    else $error("request during accept");
  start_sample_a: assert property ($rose(accept_busy_o) |-> $past(sample_i))
    else $error("accept without sample");
  accept_len_a: assert property ($rose(accept_busy_o) |-> ##[1:12] !accept_busy_o)
    else $error("accept too long");
  reset_out_a: assert property ($fell(sys_rst_i) |-> !cpu_req_o.req && !accept_busy_o
    && sfr_rdata_o == 8'h00) else $error("outputs not cleared");
  latch_low_a: assert property (sfr_i.rd && sfr_i.addr == 8'h3C |=>
    sfr_rdata_o[1:0] == 2'b00) else $error("latch low bits");
  enable_gap_a: assert property (sfr_i.rd && sfr_i.addr == 8'h3A |=>
    sfr_rdata_o[3:1] == 3'b000) else $error("enable gap bits");
  wake_up_a: assert property (sleep_fast_clock_o && cpu_req_o.req |->
    ##[0:2] !sleep_fast_clock_o) else $error("no wake");
endmodule

// ==== prioritized_interrupt_controller_tb.sv ====
// Self-checking bench for the interrupt controller.
// Assumes the CPU model drives sampling and machine cycles.
`timescale 1ns/1ps
module prioritized_interrupt_controller_tb;
  logic clk_sys_i = 0, sys_rst_i = 1, trap = 0, pin0_en = 0, mc, smp, busy, asleep;
  logic ret_m = 0, ret_n = 0, ei = 0, di = 0, slp = 0;
  logic [15:2] src = '0;
  logic [7:0] rdata;
  intc_pkg::sfr_access_t sfr = '0;
  intc_pkg::cpu_request_t req;
  int errors = 0, checks_done = 0, cyc = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  prioritized_interrupt_controller prioritized_interrupt_controller_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .source_pulse_i(src),
    .software_trap_i(trap), .pin0_function_enable_i(pin0_en), .sfr_i(sfr),
    .sample_i(smp), .machine_cycle_i(mc), .accept_ack_i(1'b0),
    .maskable_return_i(ret_m), .nonmaskable_return_i(ret_n), .enable_instruction_i(ei),
    .disable_instruction_i(di), .sleep_request_i(slp), .cpu_req_o(req),
    .sfr_rdata_o(rdata), .accept_busy_o(busy), .sleep_fast_clock_o(asleep));
  cpu_core_model cpu_core_model_inst (.clk_i(clk_sys_i), .rst_i(sys_rst_i), .busy_i(busy),
    .req_i(req.req),
    .sample_o(smp), .machine_cycle_o(mc));
  task test_done;
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task tick;
    @(posedge clk_sys_i);
    #1;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic strobe(ref logic s);
    s = 1;
    tick;
    s = 0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick;
    sfr = '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick;
    sfr = '0;
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task waitreq(input logic [15:0] v);
    for (int k = 0; k < 20 && req.req !== 1'b1; k++) tick;
    chk(req.req ? req.vector : 16'h0000, v);
  endtask
  task waitbusy(input logic b);
    for (int k = 0; k < 20 && busy !== b; k++) tick;
    chk({15'h0000, busy}, {15'h0000, b});
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    repeat (4) tick;
    sys_rst_i = 0;
    for (int k = 0; k < 4; k++) rd(8'h3A + 8'(k), 8'h00);
    wr(8'h3A, 8'hFF);
    rd(8'h3A, 8'hF1);
    wr(8'h3B, 8'hFF);
    rd(8'h3B, 8'hFF);
    strobe(di);
    rd(8'h3A, 8'hF0);
    src[15] = 1;
    src[5] = 1;
    src[4] = 1;
    tick;
    src = '0;
    rd(8'h3C, 8'h30);
    rd(8'h3D, 8'h80);
    chk({15'h0000, req.req}, 16'h0000);
    wr(8'h3C, 8'hEF);
    rd(8'h3C, 8'h20);
    wr(8'h3C, 8'hFF);
    rd(8'h3C, 8'h20);
    strobe(ei);
    waitreq(16'hFFF4);
    waitbusy(1);
    rd(8'h3C, 8'h00);
    rd(8'h3A, 8'hF0);
    waitbusy(0);
    strobe(ret_m);
    waitreq(16'hFFE0);
    waitbusy(1);
    waitbusy(0);
    src[2] = 1;
    tick;
    src = '0;
    waitreq(16'hFFFA);
    waitbusy(1);
    waitbusy(0);
    strobe(ret_n);
    rd(8'h3A, 8'hF0);
    pin0_en = 1;
    src[3] = 1;
    tick;
    src = '0;
    strobe(ei);
    waitreq(16'hFFF8);
    waitbusy(1);
    waitbusy(0);
    strobe(slp);
    tick;
    chk({15'h0000, asleep}, 16'h0001);
    src[6] = 1;
    tick;
    src = '0;
    repeat (2) tick;
    chk({15'h0000, asleep}, 16'h0000);
    trap = 1;
    waitreq(16'hFFFC);
    waitbusy(1);
    trap = 0;
    waitbusy(0);
    strobe(ret_n);
    test_done;
  end
endmodule
bind prioritized_interrupt_controller intc_checker intc_checker_inst (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .software_trap_i(software_trap_i),
  .sfr_i(sfr_i), .sample_i(sample_i), .cpu_req_o(cpu_req_o), .sfr_rdata_o(sfr_rdata_o),
  .accept_busy_o(accept_busy_o), .sleep_fast_clock_o(sleep_fast_clock_o));
